// *** pst_sequencer.sv ***
// power-state sequencer: pin sync, link write crossing, state machine, outputs
`timescale 1ns/10ps
module pst_sequencer #(
  parameter int unsigned STEP_CYC = pst_pkg::STEP_US * pst_pkg::CLK_MHZ,
  parameter int unsigned MS_CYC = pst_pkg::US_PER_MS * pst_pkg::CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic link_clk_i,
  input wire logic link_srst_i,
  input wire logic link_we_i,
  input wire logic [7:0] link_addr_i,
  input wire logic [7:0] link_data_i,
  output logic link_busy_o,
  input wire pst_pkg::pst_pins_t pins_i,
  output pst_pkg::pst_state_t state_o,
  output pst_pkg::pst_rails_t rails_o,
  output pst_pkg::pst_ctrl_t ctrl_o,
  output logic drive_enable_output_o,
  output pst_pkg::pst_irq_t irq_pending_o
);

  localparam logic [pst_pkg::TMR_W-1:0] STEP_LOAD = pst_pkg::TMR_W'(STEP_CYC - 1);
  localparam logic [pst_pkg::TMR_W-1:0] TMR_ZERO = '0;
  logic [7:0] lk_addr_q;
  logic [7:0] lk_data_q;
  logic lk_req_q;
  logic lk_busy_q;
  logic lk_ack_m_q;
  logic lk_ack_s_q;
  logic ack_q;
  // a write is held stable until the core domain acknowledges it;
  // writes offered while busy are dropped, the host watches link_busy_o
  always_ff @(posedge link_clk_i) begin
    if (link_srst_i) begin
      lk_addr_q <= 8'h00;
      lk_data_q <= 8'h00;
      lk_req_q <= 1'b0;
      lk_busy_q <= 1'b0;
    end else if (!lk_busy_q && link_we_i) begin
      lk_addr_q <= link_addr_i;
      lk_data_q <= link_data_i;
      lk_req_q <= ~lk_req_q;
      lk_busy_q <= 1'b1;
    end else if (lk_busy_q && (lk_ack_s_q == lk_req_q)) begin
      lk_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (link_srst_i) begin
      lk_ack_m_q <= 1'b0;
      lk_ack_s_q <= 1'b0;
    end else begin
      lk_ack_m_q <= ack_q;
      lk_ack_s_q <= lk_ack_m_q;
    end
  end

  assign link_busy_o = lk_busy_q;

  logic req_m_q;
  logic req_s_q;
  logic wr_stb;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      req_m_q <= 1'b0;
      req_s_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      req_m_q <= lk_req_q;
      req_s_q <= req_m_q;
      ack_q <= req_s_q;
    end
  end

  assign wr_stb = (req_s_q != ack_q);

  pst_pkg::pst_pins_t pin_m_q;
  pst_pkg::pst_pins_t pin_s_q;
  pst_pkg::pst_pins_t pin_p_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      pin_p_q <= '0;
    end else begin
      pin_m_q <= pins_i;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
    end
  end

  logic en_rise;
  logic en_fall;
  logic wake_a_fall;
  logic wake_b_fall;
  logic rtc_rise;
  assign en_rise = pin_s_q.enable & ~pin_p_q.enable;
  assign en_fall = ~pin_s_q.enable & pin_p_q.enable;
  assign wake_a_fall = ~pin_s_q.wake_pin_a & pin_p_q.wake_pin_a;
  assign wake_b_fall = ~pin_s_q.wake_pin_b & pin_p_q.wake_pin_b;
  assign rtc_rise = (pin_s_q.rtc_timer & ~pin_p_q.rtc_timer)
                  | (pin_s_q.rtc_alarm & ~pin_p_q.rtc_alarm);

  logic [1:0] sleep_q;
  logic [7:0] trig_q;
  logic deep_q;
  logic drive_q;
  logic [7:0] delay2_q;
  logic stby_req;
  pst_pkg::pst_irq_t irq_clr;
  // retention option bits are never cleared by the device itself
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sleep_q <= pst_pkg::SLEEP_RST;
      trig_q <= pst_pkg::TRIG_RST;
      deep_q <= 1'b0;
      drive_q <= 1'b0;
      delay2_q <= pst_pkg::DELAY2_RST_MS;
    end else if (wr_stb) begin
      unique case (lk_addr_q)
        pst_pkg::REG_SLEEP: sleep_q <= lk_data_q[1:0];
        pst_pkg::REG_TRIG: trig_q <= lk_data_q;
        pst_pkg::REG_DEEP: deep_q <= lk_data_q[pst_pkg::BIT_DEEP];
        pst_pkg::REG_DRIVE: drive_q <= lk_data_q[pst_pkg::BIT_DRIVE];
        pst_pkg::REG_DELAY2: delay2_q <= lk_data_q;
        default: ;
      endcase
    end
  end

  // a one written to the standby trigger bit acts as a single request
  assign stby_req = wr_stb && (lk_addr_q == pst_pkg::REG_TRIG)
                 && lk_data_q[pst_pkg::BIT_STBY_TRIG];

  always_comb begin
    irq_clr = '0;
    if (wr_stb) begin
      irq_clr.wake_a = (lk_addr_q == pst_pkg::REG_INT_GPIO)
                     && lk_data_q[pst_pkg::BIT_WAKE_A_INT];
      irq_clr.enable = (lk_addr_q == pst_pkg::REG_INT_EN)
                     && lk_data_q[pst_pkg::BIT_EN_INT];
      irq_clr.self_test_pass = (lk_addr_q == pst_pkg::REG_INT_MISC)
                     && lk_data_q[pst_pkg::BIT_PASS_INT];
    end
  end

  pst_pkg::pst_state_t state_q;
  pst_pkg::pst_state_t state_d;
  logic [pst_pkg::TMR_W-1:0] tmr_q;
  logic [2:0] step_q;
  logic stby_host_q;
  pst_pkg::pst_irq_t irq_q;
  logic sleep1;
  logic sleep2;
  logic mem_ret;
  logic io_ret;
  logic blocked;
  logic step_tick;
  logic up_done;
  logic go_up;
  logic go_ret;
  logic go_stby;
  logic go_mcu;
  logic wake_up;
  // sleep request holds only while both register bit and pin ask for it
  assign sleep1 = sleep_q[0] & pin_s_q.sleep_control_first;
  assign sleep2 = sleep_q[1] & pin_s_q.sleep_control_second;
  assign mem_ret = trig_q[pst_pkg::BIT_MEM_RET];
  assign io_ret = trig_q[pst_pkg::BIT_IO_RET];
  // a pending wake interrupt gates triggers too, so the host can restore
  // the sleep bits after a wake without falling straight back
  assign blocked = irq_q.enable | irq_q.wake_a;
  assign step_tick = (state_q == pst_pkg::ST_PWRUP) && (tmr_q == TMR_ZERO);
  assign up_done = step_tick && (step_q == pst_pkg::RAIL_LAST);

  always_comb begin
    state_d = state_q;
    go_up = 1'b0;
    go_ret = 1'b0;
    go_stby = 1'b0;
    go_mcu = 1'b0;
    wake_up = 1'b0;
    unique case (state_q)
      pst_pkg::ST_OFF: begin
        go_up = en_rise;
      end
      pst_pkg::ST_PWRUP: begin
        if (up_done) begin
          state_d = pst_pkg::ST_ACTIVE;
        end
      end
      pst_pkg::ST_ACTIVE: begin
        if (en_fall || stby_req) begin
          go_stby = 1'b1;
        end else if (!blocked) begin
          go_mcu = !sleep1 && sleep2;
          go_ret = !sleep1 && !sleep2;
        end
      end
      pst_pkg::ST_MCU: begin
        if (!blocked) begin
          go_up = sleep1 && sleep2;
          go_ret = !sleep1 && !sleep2;
        end
      end
      pst_pkg::ST_RET_ENTRY: begin
        state_d = pst_pkg::ST_RET_DELAY;
      end
      pst_pkg::ST_RET_DELAY: begin
        if (tmr_q == TMR_ZERO) begin
          state_d = pst_pkg::ST_RETENTION;
        end
      end
      pst_pkg::ST_RETENTION: begin
        if (en_fall || stby_req) begin
          go_stby = 1'b1;
        end else begin
          wake_up = wake_a_fall;
          go_up = wake_a_fall;
        end
      end
      pst_pkg::ST_STBY_ENTRY: begin
        state_d = deep_q ? pst_pkg::ST_DEEP_STBY : pst_pkg::ST_STANDBY;
      end
      pst_pkg::ST_STANDBY: begin
        wake_up = stby_host_q && wake_a_fall;
        go_up = en_rise
             || (stby_host_q && (wake_a_fall || wake_b_fall || rtc_rise));
      end
      pst_pkg::ST_DEEP_STBY: begin
        go_up = en_rise;
      end
      default: begin
        state_d = pst_pkg::ST_OFF;
      end
    endcase
    if (go_up) begin
      state_d = pst_pkg::ST_PWRUP;
    end else if (go_stby) begin
      state_d = pst_pkg::ST_STBY_ENTRY;
    end else if (go_ret) begin
      state_d = pst_pkg::ST_RET_ENTRY;
    end else if (go_mcu) begin
      state_d = pst_pkg::ST_MCU;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= pst_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end
  // remembers whether standby was entered by the host trigger
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stby_host_q <= 1'b0;
    end else if (go_stby) begin
      stby_host_q <= stby_req && !en_fall;
    end
  end
  // one timer serves the power-up steps and the retention delay
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tmr_q <= TMR_ZERO;
      step_q <= 3'h0;
    end else if (go_up) begin
      tmr_q <= STEP_LOAD;
      step_q <= 3'h0;
    end else if (state_q == pst_pkg::ST_PWRUP) begin
      if (tmr_q == TMR_ZERO) begin
        tmr_q <= STEP_LOAD;
        step_q <= step_q + 3'h1;
      end else begin
        tmr_q <= tmr_q - 1'b1;
      end
    end else if (state_q == pst_pkg::ST_RET_ENTRY) begin
      tmr_q <= pst_pkg::TMR_W'(delay2_q * MS_CYC);
    end else if (tmr_q != TMR_ZERO) begin
      tmr_q <= tmr_q - 1'b1;
    end
  end

  pst_pkg::pst_rails_t rails_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rails_q <= '0;
    end else if (step_tick) begin
      rails_q[step_q] <= 1'b1;
    end else if (go_mcu) begin
      rails_q[pst_pkg::RAIL_SOC] <= 1'b0;
      rails_q[pst_pkg::RAIL_IO_RET] <= 1'b0;
      rails_q[pst_pkg::RAIL_MEM_SUP] <= mem_ret;
      rails_q[pst_pkg::RAIL_MEM_RET] <= mem_ret;
    end else if (state_q == pst_pkg::ST_RET_ENTRY) begin
      rails_q <= '0;
      rails_q[pst_pkg::RAIL_MEM_SUP] <= mem_ret;
      rails_q[pst_pkg::RAIL_MEM_RET] <= mem_ret;
      rails_q[pst_pkg::RAIL_IO_RET] <= io_ret;
    end else if (state_q == pst_pkg::ST_STBY_ENTRY) begin
      rails_q <= '0;
    end
  end

  pst_pkg::pst_ctrl_t ctrl_q;
  logic drv_out_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_q <= '0;
      ctrl_q.force_drive_enable_low <= 1'b1;
    end else if (go_up) begin
      ctrl_q.serial_low_power_enable <= 1'b0;
      ctrl_q.low_power_enable <= 1'b0;
      ctrl_q.analog_mux_output_enable <= 1'b1;
      ctrl_q.clock_monitor_enable <= 1'b1;
    end else if (up_done) begin
      ctrl_q.force_drive_enable_low <= 1'b0;
    end else if ((state_q == pst_pkg::ST_RET_ENTRY)
              || (state_q == pst_pkg::ST_STBY_ENTRY)) begin
      ctrl_q.low_power_enable <= 1'b1;
      ctrl_q.analog_mux_output_enable <= 1'b0;
    end
  end
  // the drive pin follows the host bit only once the force is released
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      drv_out_q <= 1'b0;
    end else begin
      drv_out_q <= drive_q & ~ctrl_q.force_drive_enable_low;
    end
  end

  pst_pkg::pst_irq_t irq_set;
  logic up_en_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      up_en_q <= 1'b0;
    end else if (go_up) begin
      up_en_q <= en_rise;
    end
  end

  assign irq_set = '{wake_a: wake_up, enable: up_done && up_en_q,
                     self_test_pass: up_done && up_en_q};

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_q <= '0;
    end else begin
      irq_q <= (irq_q & ~irq_clr) | irq_set;
    end
  end

  assign state_o = state_q;
  assign rails_o = rails_q;
  assign ctrl_o = ctrl_q;
  assign drive_enable_output_o = drv_out_q;
  assign irq_pending_o = irq_q;

endmodule : pst_sequencer

// *** pst_pkg.sv ***
// types, constants and register map of the power-state sequencer
package pst_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned US_PER_MS = 1000;
  // rail-to-rail spacing of the power-up order, microseconds
  localparam int unsigned STEP_US = 500;

  localparam int unsigned TMR_W = 24;
  localparam int unsigned RAIL_N = 5;
  localparam logic [2:0] RAIL_LAST = 3'h4;

  // rail index is also the position in the power-up order
  localparam int unsigned RAIL_MEM_SUP = 0;
  localparam int unsigned RAIL_MEM_RET = 1;
  localparam int unsigned RAIL_MCU = 2;
  localparam int unsigned RAIL_IO_RET = 3;
  localparam int unsigned RAIL_SOC = 4;

  // link register addresses and bit positions
  localparam logic [7:0] REG_DRIVE = 8'h82;
  localparam logic [7:0] REG_TRIG = 8'h85;
  localparam logic [7:0] REG_SLEEP = 8'h86;
  localparam logic [7:0] REG_INT_GPIO = 8'h64;
  localparam logic [7:0] REG_INT_EN = 8'h65;
  localparam logic [7:0] REG_INT_MISC = 8'h66;
  localparam logic [7:0] REG_DEEP = 8'hC3;
  localparam logic [7:0] REG_DELAY2 = 8'hCE;
  localparam int unsigned BIT_DRIVE = 0;
  localparam int unsigned BIT_STBY_TRIG = 0;
  localparam int unsigned BIT_IO_RET = 5;
  localparam int unsigned BIT_MEM_RET = 7;
  localparam int unsigned BIT_WAKE_A_INT = 3;
  localparam int unsigned BIT_EN_INT = 1;
  localparam int unsigned BIT_PASS_INT = 0;
  localparam int unsigned BIT_DEEP = 3;

  localparam logic [1:0] SLEEP_RST = 2'h0;
  localparam logic [7:0] TRIG_RST = 8'h00;
  localparam logic [7:0] DELAY2_RST_MS = 8'h10;

  typedef enum logic [3:0] {
    ST_OFF = 4'h0,
    ST_PWRUP = 4'h1,
    ST_ACTIVE = 4'h3,
    ST_MCU = 4'h2,
    ST_RET_ENTRY = 4'h6,
    ST_RET_DELAY = 4'h7,
    ST_RETENTION = 4'h5,
    ST_STBY_ENTRY = 4'h4,
    ST_STANDBY = 4'hC,
    ST_DEEP_STBY = 4'hD
  } pst_state_t;

  typedef logic [RAIL_N-1:0] pst_rails_t;

  typedef struct packed {
    logic serial_low_power_enable;
    logic low_power_enable;
    logic analog_mux_output_enable;
    logic clock_monitor_enable;
    logic force_drive_enable_low;
  } pst_ctrl_t;

  typedef struct packed {
    logic enable;
    logic sleep_control_first;
    logic sleep_control_second;
    logic wake_pin_a;
    logic wake_pin_b;
    logic rtc_timer;
    logic rtc_alarm;
  } pst_pins_t;

  typedef struct packed {
    logic wake_a;
    logic enable;
    logic self_test_pass;
  } pst_irq_t;

endpackage : pst_pkg

// *** pst_host_model.sv ***
// host model: one byte written per link transfer
`timescale 1ns/10ps
module pst_host_model (
  input wire logic link_clk_i,
  input wire logic link_busy_i,
  output logic we_o,
  output logic [7:0] addr_o,
  output logic [7:0] data_o
);
  initial begin
    we_o = 1'b0;
    addr_o = 8'h00;
    data_o = 8'h00;
  end

  // data is written as given; the link has no read, so nothing is merged
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge link_clk_i);
    we_o = 1'b1;
    addr_o = a;
    data_o = d;
    do @(posedge link_clk_i); while (link_busy_i);
    // taken at this edge: release just after it, and show no stale value
    we_o <= 1'b0;
    addr_o <= ~a;
    data_o <= ~d;
    repeat (2) @(posedge link_clk_i);
    while (link_busy_i) @(posedge link_clk_i);
  endtask : wr
endmodule : pst_host_model

// *** pst_sequencer_chk.sv ***
// port assertions for the power-state sequencer
`timescale 1ns/10ps
module pst_sequencer_chk #(
  parameter int unsigned MS_CYC = 20000
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire pst_pkg::pst_state_t state_o,
  input wire pst_pkg::pst_rails_t rails_o,
  input wire pst_pkg::pst_ctrl_t ctrl_o,
  input wire logic drive_enable_output_o,
  input wire pst_pkg::pst_irq_t irq_pending_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [31:0] dly_q;

  // cycles spent in the post-retention wait
  always_ff @(posedge clk_i) begin
    if (srst_i || state_o != pst_pkg::ST_RET_DELAY) dly_q <= 32'h0000_0000;
    else dly_q <= dly_q + 32'h0000_0001;
  end

  a_rail_order: assert property (
    $past(state_o) == pst_pkg::ST_PWRUP && state_o == pst_pkg::ST_PWRUP
    && rails_o != $past(rails_o) |-> $onehot(rails_o ^ $past(rails_o))
    && (((rails_o ^ $past(rails_o)) - 1) & ~rails_o) == 0
    && ((rails_o ^ $past(rails_o)) & ~rails_o) == 0)
    else $error("rail enabled out of order");
  a_pwrup_ctrl: assert property (
    state_o == pst_pkg::ST_PWRUP && $past(state_o) != pst_pkg::ST_PWRUP |-> ##[0:1]
    (!ctrl_o.serial_low_power_enable && !ctrl_o.low_power_enable
    && ctrl_o.analog_mux_output_enable && ctrl_o.clock_monitor_enable))
    else $error("control bits wrong at power-up start");
  a_active_done: assert property (
    $past(state_o) == pst_pkg::ST_PWRUP && state_o == pst_pkg::ST_ACTIVE |-> ##[0:1]
    (!ctrl_o.force_drive_enable_low && rails_o == 5'h1f))
    else $error("power-up ended incomplete");
  a_ret_rails: assert property (
    state_o == pst_pkg::ST_RETENTION |-> !rails_o[pst_pkg::RAIL_MCU]
    && !rails_o[pst_pkg::RAIL_SOC])
    else $error("non-retention rail on in retention");
  a_ret_ctrl: assert property (
    state_o == pst_pkg::ST_RET_DELAY |->
    ctrl_o.low_power_enable && !ctrl_o.analog_mux_output_enable)
    else $error("control bits wrong after retention entry");
  a_ret_delay: assert property (
    $past(state_o) == pst_pkg::ST_RET_DELAY && state_o == pst_pkg::ST_RETENTION |->
    dly_q + 1 >= pst_pkg::DELAY2_RST_MS * MS_CYC
    && dly_q <= pst_pkg::DELAY2_RST_MS * MS_CYC + 1)
    else $error("retention wait length wrong");
  a_irq_block: assert property (
    state_o == pst_pkg::ST_ACTIVE && irq_pending_o.enable |=>
    state_o inside {pst_pkg::ST_ACTIVE, pst_pkg::ST_STBY_ENTRY})
    else $error("trigger taken while enable interrupt pending");
  a_stby_rails: assert property (
    state_o inside {pst_pkg::ST_STANDBY, pst_pkg::ST_DEEP_STBY} |-> rails_o == 5'h00)
    else $error("rail on in standby");
  a_stby_exit: assert property (
    $past(state_o) inside {pst_pkg::ST_STANDBY, pst_pkg::ST_DEEP_STBY}
    && $changed(state_o) |-> state_o == pst_pkg::ST_PWRUP)
    else $error("standby left for a wrong state");
  a_drive_gate: assert property (
    drive_enable_output_o |-> !$past(ctrl_o.force_drive_enable_low))
    else $error("drive output high while forced low");
  a_ret_exit: assert property (
    $past(state_o) == pst_pkg::ST_RETENTION && $changed(state_o) |->
    state_o inside {pst_pkg::ST_PWRUP, pst_pkg::ST_STBY_ENTRY})
    else $error("retention left without wake");
endmodule : pst_sequencer_chk

bind pst_sequencer pst_sequencer_chk #(.MS_CYC(MS_CYC)) i_chk (
  .clk_i(clk_i),
  .srst_i(srst_i),
  .state_o(state_o),
  .rails_o(rails_o),
  .ctrl_o(ctrl_o),
  .drive_enable_output_o(drive_enable_output_o),
  .irq_pending_o(irq_pending_o)
);

// *** test_pst_sequencer.sv ***
// self-checking bench for the power-state sequencer
`timescale 1ns/10ps
module test_pst_sequencer;
  typedef pst_pkg::pst_state_t st_t;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic srst = 1'b1;
  logic we;
  logic busy;
  logic drv;
  logic [7:0] addr;
  logic [7:0] data;
  // wake pins held high before any retention, sleep pins start high
  pst_pkg::pst_pins_t pins = 7'h3c;
  st_t state;
  pst_pkg::pst_rails_t rails;
  pst_pkg::pst_ctrl_t ctrl;
  pst_pkg::pst_irq_t irq;
  st_t exp_q[$];
  st_t last_st = pst_pkg::ST_OFF;
  int n_fail = 0;
  int checks_done = 0;
  int seed = 32'h5b0e_1252;
  int n;

  always #25 clk = ~clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  pst_sequencer #(.STEP_CYC(4), .MS_CYC(10)) i_dut (
    .clk_i(clk), .srst_i(srst), .link_clk_i(link_clk), .link_srst_i(srst),
    .link_we_i(we), .link_addr_i(addr), .link_data_i(data), .link_busy_o(busy),
    .pins_i(pins), .state_o(state), .rails_o(rails), .ctrl_o(ctrl),
    .drive_enable_output_o(drv), .irq_pending_o(irq));
  pst_host_model i_host (.link_clk_i(link_clk), .link_busy_i(busy), .we_o(we),
    .addr_o(addr), .data_o(data));

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic final_report();
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic nt(input st_t a, input st_t b = pst_pkg::ST_OFF,
                    input st_t c = pst_pkg::ST_OFF);
    exp_q.push_back(a);
    if (b != pst_pkg::ST_OFF) exp_q.push_back(b);
    if (c != pst_pkg::ST_OFF) exp_q.push_back(c);
  endtask : nt

  task automatic ws(input st_t s, input int k = 2);
    int i;
    for (i = 0; i < 3000 && state !== s; i++) @(negedge clk);
    if (state !== s) chk("wait", state, s);
    repeat (k) @(negedge clk);
  endtask : ws

  // any state change not announced beforehand is a mismatch
  always @(negedge clk) begin
    if (!srst && state !== last_st) begin
      last_st = state;
      if (exp_q.size() == 0) chk("state", state, 'x);
      else chk("state", state, exp_q.pop_front());
    end
  end

  initial begin
    repeat (8) @(negedge clk);
    chk("reset", {state, rails, ctrl, irq, drv}, 18'h0_0010);
    srst = 1'b0;
    nt(pst_pkg::ST_PWRUP, pst_pkg::ST_ACTIVE);
    pins.enable = 1'b1;
    ws(pst_pkg::ST_PWRUP);
    chk("ctrl", ctrl, 5'h07);
    ws(pst_pkg::ST_ACTIVE);
    chk("rails", rails, 5'h1f);
    chk("ctrl", ctrl, 5'h06);
    chk("irq", irq, 3'h3);
    i_host.wr(8'h10, 8'($random(seed)));
    i_host.wr(pst_pkg::REG_DRIVE, 8'h01);
    repeat (10) @(negedge clk);
    chk("drive", drv, 1'b1);
    i_host.wr(pst_pkg::REG_TRIG, 8'h80);
    i_host.wr(pst_pkg::REG_SLEEP, 8'h02);
    repeat (20) @(negedge clk);
    nt(pst_pkg::ST_MCU);
    i_host.wr(pst_pkg::REG_INT_EN, 8'h02);
    ws(pst_pkg::ST_MCU);
    chk("irq", irq, 3'h1);
    chk("rails", rails, 5'h07);
    i_host.wr(pst_pkg::REG_INT_MISC, 8'h01);
    chk("irq", irq, 3'h0);
    @(negedge clk);
    nt(pst_pkg::ST_RET_ENTRY, pst_pkg::ST_RET_DELAY, pst_pkg::ST_RETENTION);
    pins.sleep_control_second = 1'b0;
    ws(pst_pkg::ST_RET_DELAY, 0);
    chk("lpe amux", {ctrl.low_power_enable, ctrl.analog_mux_output_enable}, 2'h2);
    for (n = 0; n < 400 && state !== pst_pkg::ST_RETENTION; n++) @(negedge clk);
    chk("delay", n >= 159 && n <= 161, 1'b1);
    repeat (2) @(negedge clk);
    chk("rails", rails, 5'h03);
    nt(pst_pkg::ST_PWRUP, pst_pkg::ST_ACTIVE);
    pins.wake_pin_a = 1'b0;
    ws(pst_pkg::ST_ACTIVE);
    chk("irq", irq, 3'h4);
    pins.wake_pin_a = 1'b1;
    pins.sleep_control_second = 1'b1;
    i_host.wr(pst_pkg::REG_SLEEP, 8'h00);
    i_host.wr(pst_pkg::REG_TRIG, 8'h20);
    nt(pst_pkg::ST_RET_ENTRY, pst_pkg::ST_RET_DELAY, pst_pkg::ST_RETENTION);
    i_host.wr(pst_pkg::REG_INT_GPIO, 8'h08);
    ws(pst_pkg::ST_RETENTION);
    chk("rails", rails, 5'h08);
    nt(pst_pkg::ST_STBY_ENTRY, pst_pkg::ST_STANDBY);
    pins.enable = 1'b0;
    ws(pst_pkg::ST_STANDBY);
    chk("rails", rails, 5'h00);
    nt(pst_pkg::ST_PWRUP, pst_pkg::ST_ACTIVE);
    pins.enable = 1'b1;
    ws(pst_pkg::ST_ACTIVE);
    chk("irq", irq, 3'h3);
    i_host.wr(pst_pkg::REG_TRIG, 8'h00);
    nt(pst_pkg::ST_RET_ENTRY, pst_pkg::ST_RET_DELAY, pst_pkg::ST_RETENTION);
    i_host.wr(pst_pkg::REG_INT_EN, 8'h02);
    i_host.wr(pst_pkg::REG_INT_MISC, 8'h01);
    ws(pst_pkg::ST_RETENTION);
    chk("rails", rails, 5'h00);
    i_host.wr(pst_pkg::REG_SLEEP, 8'h03);
    nt(pst_pkg::ST_STBY_ENTRY, pst_pkg::ST_STANDBY);
    i_host.wr(pst_pkg::REG_TRIG, 8'h01);
    ws(pst_pkg::ST_STANDBY);
    nt(pst_pkg::ST_PWRUP, pst_pkg::ST_ACTIVE);
    pins.wake_pin_b = 1'b0;
    ws(pst_pkg::ST_ACTIVE);
    pins.wake_pin_b = 1'b1;
    i_host.wr(pst_pkg::REG_DEEP, 8'h08);
    nt(pst_pkg::ST_STBY_ENTRY, pst_pkg::ST_DEEP_STBY);
    i_host.wr(pst_pkg::REG_TRIG, 8'h01);
    ws(pst_pkg::ST_DEEP_STBY);
    // deep standby ignores the pin wakes
    pins.wake_pin_b = 1'b0;
    pins.rtc_timer = 1'($random(seed));
    pins.enable = 1'b0;
    repeat (20) @(negedge clk);
    nt(pst_pkg::ST_PWRUP, pst_pkg::ST_ACTIVE);
    pins.enable = 1'b1;
    ws(pst_pkg::ST_ACTIVE);
    chk("rails", rails, 5'h1f);
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule : test_pst_sequencer
